// ### current_dac_defs.vh
`ifndef CURRENT_DAC_DEFS_VH
`define CURRENT_DAC_DEFS_VH
// register addresses on the special-function-register bus
`define ADDR_DATA_LOW      8'h96
`define ADDR_DATA_HIGH     8'h97
`define ADDR_CONTROL       8'hb9
// reset values
`define CONTROL_RESET      8'h72
`define DATA_RESET         8'h00
// control fields
`define CTL_ENABLE_BIT     7
`define CTL_SRC_HI         6
`define CTL_SRC_LO         4
`define CTL_RANGE_HI       1
`define CTL_RANGE_LO       0
`define CTL_WRITE_MASK     8'hf3
`define LOW_WRITE_MASK     8'hc0
// update source codes
`define SRC_TIMER0         3'h0
`define SRC_TIMER1         3'h1
`define SRC_TIMER2         3'h2
`define SRC_TIMER3         3'h3
`define SRC_PIN_RISE       3'h4
`define SRC_PIN_FALL       3'h5
`define SRC_PIN_ANY        3'h6
`define SRC_ON_DEMAND      3'h7
// full-scale range codes
`define RANGE_HALF_MA      2'h0
`define RANGE_ONE_MA       2'h1
`define RANGE_TWO_MA       2'h2
// storage shape and idle values
`define REG_WIDTH          8
`define LOW_DATA_HI        7
`define LOW_DATA_LO        6
`define CODE_RESET         10'h000
`define READ_IDLE          8'h00
`define PIN_IDLE           1'b0
`define ENABLE_RESET       1'b0
`define SYNC_STAGES        3
`endif

// ### current_dac_update_scheduler.v
`timescale 1ns/1ps
`default_nettype none
`include "current_dac_defs.vh"

module current_dac_update_scheduler (
  input  wire       CLOCK_I,
  input  wire       RST_I,
  input  wire [7:0] SFR_ADDR_I,
  input  wire [7:0] SFR_WDATA_I,
  input  wire       SFR_WRITE_I,
  input  wire       SFR_READ_I,
  output reg  [7:0] SFR_RDATA_O,
  output wire       SFR_HIT_O,
  input  wire [3:0] TIMER_OVERFLOW_I,
  input  wire       CONVERSION_START_PIN_I,
  output reg  [9:0] DAC_CODE_O,
  output reg  [1:0] FULL_SCALE_O,
  output reg        CONVERTER_ENABLE_O,
  output reg        PIN_ANALOG_O
);

  wire [7:0] control;
  wire [7:0] data_low;
  wire [7:0] data_high;
  wire       rise;
  wire       fall;
  reg        wr_low;
  reg        wr_high;
  reg        wr_ctl;
  reg        load;
  reg  [7:0] next_rdata;
  reg  [9:0] next_code;

  // update source field, decoded below
  wire [2:0] source = control[`CTL_SRC_HI:`CTL_SRC_LO];

  // one strobe per mapped address; unmapped writes fall through
  // at most one strobe is high, as the addresses are distinct
  always @*
  begin
    wr_low  = 1'b0;
    wr_high = 1'b0;
    wr_ctl  = 1'b0;
    if (SFR_WRITE_I)
    begin
      case (SFR_ADDR_I)
        `ADDR_DATA_LOW:  wr_low  = 1'b1;
        `ADDR_DATA_HIGH: wr_high = 1'b1;
        `ADDR_CONTROL:   wr_ctl  = 1'b1;
        default:         wr_ctl  = 1'b0;
      endcase
    end
  end

  // bus decode hit for the surrounding read mux
  assign SFR_HIT_O = (SFR_ADDR_I == `ADDR_DATA_LOW) ||
                     (SFR_ADDR_I == `ADDR_DATA_HIGH) ||
                     (SFR_ADDR_I == `ADDR_CONTROL);

  // pick the one event that may load the latches
  always @*
  begin
    case (source)
      `SRC_TIMER0:    load = TIMER_OVERFLOW_I[0];
      `SRC_TIMER1:    load = TIMER_OVERFLOW_I[1];
      `SRC_TIMER2:    load = TIMER_OVERFLOW_I[2];
      `SRC_TIMER3:    load = TIMER_OVERFLOW_I[3];
      `SRC_PIN_RISE:  load = rise;
      `SRC_PIN_FALL:  load = fall;
      `SRC_PIN_ANY:   load = rise | fall;
      `SRC_ON_DEMAND: load = wr_high;
      default:        load = 1'b0;
    endcase
  end

  // pin edges count once the last two stages agree
  pin_edge_sync #(
    .STAGES (`SYNC_STAGES)
  )
  i_pin_sync
  (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .pin_i  (CONVERSION_START_PIN_I),
    .rise_o (rise),
    .fall_o (fall)
  );

  masked_reg #(
    .WIDTH     (`REG_WIDTH),
    .RESET_VAL (`CONTROL_RESET),
    .KEEP_MASK (`CTL_WRITE_MASK)
  )
  i_control
  (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .write_i (wr_ctl),
    .data_i  (SFR_WDATA_I),
    .value_o (control)
  );

  masked_reg #(
    .WIDTH     (`REG_WIDTH),
    .RESET_VAL (`DATA_RESET),
    .KEEP_MASK (`LOW_WRITE_MASK)
  )
  i_data_low
  (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .write_i (wr_low),
    .data_i  (SFR_WDATA_I),
    .value_o (data_low)
  );

  // high byte, plain storage; timer and pin loads read it later
  masked_reg #(
    .WIDTH     (`REG_WIDTH),
    .RESET_VAL (`DATA_RESET),
    .KEEP_MASK (`CTL_WRITE_MASK | ~`CTL_WRITE_MASK)
  )
  i_data_high
  (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .write_i (wr_high),
    .data_i  (SFR_WDATA_I),
    .value_o (data_high)
  );

  // on-demand takes the byte being written this cycle; the new high
  // byte bypasses the register it is landing in
  always @*
  begin
    next_code = {data_high, data_low[`LOW_DATA_HI:`LOW_DATA_LO]};
    if (wr_high)
      next_code = {SFR_WDATA_I, data_low[`LOW_DATA_HI:`LOW_DATA_LO]};
  end

  // input latches; held between loads so the output never tears
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
      DAC_CODE_O <= `CODE_RESET;
    else if (load)
    begin
      DAC_CODE_O <= next_code;
    end
  end

  // range decode, registered so the current source sees a clean code
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
      FULL_SCALE_O <= `RANGE_TWO_MA;
    // range decode, 1x folds to two mA
    else if (control[`CTL_RANGE_HI])
      FULL_SCALE_O <= `RANGE_TWO_MA;
    else
      FULL_SCALE_O <= control[`CTL_RANGE_HI:`CTL_RANGE_LO];
  end

  // enable and pin handover move together, one cycle after the control register takes the write
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      CONVERTER_ENABLE_O <= `ENABLE_RESET;
      PIN_ANALOG_O       <= `ENABLE_RESET;
    end
    else
    begin
      CONVERTER_ENABLE_O <= control[`CTL_ENABLE_BIT];
      PIN_ANALOG_O       <= control[`CTL_ENABLE_BIT];
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    next_rdata = `READ_IDLE;
    case (SFR_ADDR_I)
      `ADDR_DATA_LOW:  next_rdata = data_low;
      `ADDR_DATA_HIGH: next_rdata = data_high;
      `ADDR_CONTROL:   next_rdata = control;
      default:         next_rdata = `READ_IDLE;
    endcase
  end

  // read data held in a flop, one cycle after the read strobe
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
      SFR_RDATA_O <= `READ_IDLE;
    else if (SFR_READ_I)
      SFR_RDATA_O <= next_rdata;
  end

endmodule // current_dac_update_scheduler

// one register byte; masked bits stay zero and read back as zero
module masked_reg #(
  parameter             WIDTH     = `REG_WIDTH,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] KEEP_MASK = {WIDTH{1'b1}}
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             write_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] value_o
);

  // masking on the way in keeps the read path free of gates
  // a write and a reset in one cycle: reset wins
  always @(posedge clk_i)
  begin
    if (rst_i)
      value_o <= RESET_VAL;
    else if (write_i)
      value_o <= data_i & KEEP_MASK;
  end

endmodule // masked_reg

// pin synchroniser; a change counts once the last two stages agree
module pin_edge_sync #(
  parameter STAGES = `SYNC_STAGES
)
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire rise_o,
  output wire fall_o
);

  // latency: a pin change shows as a pulse three to four edges later
  reg  [STAGES-1:0] stage;
  reg               level;
  reg               next_level;
  wire              settled;

  // the third stage must match the second before anything moves
  assign settled = (stage[STAGES-1] == stage[STAGES-2]);

  // edge pulses last one cycle: level follows on the next edge
  assign rise_o = settled && stage[STAGES-1] && !level;
  assign fall_o = settled && !stage[STAGES-1] && level;

  // level only moves on an agreed sample, so a glitch never toggles it
  always @*
  begin
    next_level = level;
    if (settled)
      next_level = stage[STAGES-1];
  end

  // shift in the raw pin; stage 0 is only read by stage 1
  // level resets to the idle low, so no edge follows reset while the pin is low
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage <= {STAGES{`PIN_IDLE}};
      level <= `PIN_IDLE;
    end
    else
    begin
      stage <= {stage[STAGES-2:0], pin_i};
      level <= next_level;
    end
  end

endmodule // pin_edge_sync
`default_nettype wire

// ### sfr_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_cpu (
  input  wire logic       clk_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       write_o,
  output var  logic       read_o
);
  // idle bus: strobes low, released lines flipped so stale data shows
  initial {write_o, read_o, addr_o, wdata_o} = 18'h0;
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    #1 {write_o, read_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge clk_i);
    #1 {write_o, read_o, addr_o, wdata_o} <= {2'h0, ~a, ~d};
  endtask
endmodule // sfr_cpu
`default_nettype wire

// ### dac_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dac_monitor (
  input wire logic       CLOCK_I,
  input wire logic       RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic       SFR_WRITE_I,
  input wire logic       SFR_READ_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [3:0] TIMER_OVERFLOW_I,
  input wire logic [9:0] DAC_CODE_O,
  input wire logic [1:0] FULL_SCALE_O
);
  logic [7:0] ctl, lo, hi;
  wire       hw = SFR_WRITE_I && SFR_ADDR_I == 8'h97;
  wire [9:0] word = {hi, lo[7:6]};
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // shadow of the stored bits; one address a cycle, so no overlap
  always @(posedge CLOCK_I)
    if (RST_I)
      {ctl, lo, hi} <= 24'h720000;
    else if (hw)
      hi <= SFR_WDATA_I;
    else if (SFR_WRITE_I && SFR_ADDR_I == 8'h96)
      lo <= SFR_WDATA_I & 8'hc0;
    else if (SFR_WRITE_I && SFR_ADDR_I == 8'hb9)
      ctl <= SFR_WDATA_I & 8'hf3;
  a_demand_load: assert property (hw && ctl[6:4] == 3'h7 |=>
    DAC_CODE_O == word) else $error("no load on high write");
  a_low_held: assert property ($changed(DAC_CODE_O) &&
    $past(ctl[6:4]) == 3'h7 |-> $past(hw)) else $error("stray load");
  a_timer_load: assert property (!ctl[6] && !SFR_WRITE_I &&
    TIMER_OVERFLOW_I[ctl[5:4]] |=> DAC_CODE_O == word) else $error("timer");
  a_other_quiet: assert property ($changed(DAC_CODE_O) &&
    !$past(ctl[6]) |-> $past(TIMER_OVERFLOW_I[ctl[5:4]])) else $error("src");
  a_pin_load: assert property ($changed(DAC_CODE_O) &&
    $past(ctl[6:4]) inside {[4:6]} |-> DAC_CODE_O == $past(word))
    else $error("pin load word");
  a_low_read: assert property (SFR_READ_I && SFR_ADDR_I == 8'h96 |=>
    SFR_RDATA_O == $past(lo)) else $error("low read");
  a_ctl_read: assert property (SFR_READ_I && SFR_ADDR_I == 8'hb9 |=>
    SFR_RDATA_O == $past(ctl)) else $error("control read");
  a_range_map: assert property (FULL_SCALE_O ==
    ($past(ctl[1]) ? 2'h2 : $past(ctl[1:0]))) else $error("range");
  cover property (hw && ctl[6:4] == 3'h7);
  cover property (!ctl[6] && TIMER_OVERFLOW_I[ctl[5:4]]);
  cover property ($changed(DAC_CODE_O) && ctl[6:4] == 3'h6);
endmodule // dac_monitor
bind current_dac_update_scheduler dac_monitor i_mon (.*);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module tb_top;
  logic CLOCK_I = 0, RST_I = 1, CONVERSION_START_PIN_I = 0, SFR_WRITE_I;
  logic SFR_READ_I, SFR_HIT_O, CONVERTER_ENABLE_O, PIN_ANALOG_O, rdp = 0;
  logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, r, rq[$];
  logic [3:0] TIMER_OVERFLOW_I = 0;
  logic [1:0] FULL_SCALE_O;
  logic [9:0] DAC_CODE_O, last = 0, cur = 0, e, dq[$];
  int n_fail = 0, checks = 0;
  integer seed = 32'h5bbd83cb;
  always #12.5 CLOCK_I = ~CLOCK_I;
  current_dac_update_scheduler i_dut (.*);
  sfr_cpu i_cpu (.clk_i(CLOCK_I), .addr_o(SFR_ADDR_I), .wdata_o(SFR_WDATA_I),
    .write_o(SFR_WRITE_I), .read_o(SFR_READ_I));
  task rdx(input logic [7:0] a, x);
    rq.push_back(x);
    i_cpu.acc(0, a, 8'h00);
  endtask
  // note a load only when the word really changes
  task ld(input logic [9:0] v);
    if (v !== cur) dq.push_back(v);
    cur = v;
  endtask
  task tick(input logic [3:0] m);
    @(posedge CLOCK_I) #1 TIMER_OVERFLOW_I = m;
    @(posedge CLOCK_I) #1 TIMER_OVERFLOW_I = 4'h0;
  endtask
  // 8 cycles covers the pin synchroniser delay
  task pin(input logic v);
    @(posedge CLOCK_I) #1 CONVERSION_START_PIN_I = v;
    repeat (8) @(posedge CLOCK_I);
  endtask
  // results show one edge late; each takes the oldest note
  always @(posedge CLOCK_I) begin
    if (rdp) begin
      e = rq.pop_front();
      `CHK(SFR_RDATA_O, e[7:0])
    end
    if (!RST_I && DAC_CODE_O !== last) begin
      e = dq.pop_front();
      `CHK(DAC_CODE_O, e)
    end
    if (SFR_READ_I)
      `CHK(SFR_HIT_O, (SFR_ADDR_I inside {8'h96, 8'h97, 8'hb9}))
    last = DAC_CODE_O;
    rdp = SFR_READ_I;
  end
  initial begin
    repeat (16) @(posedge CLOCK_I);
    #1 RST_I = 0;
    // reset state; unmapped place reads zero
    rdx(8'hb9, 8'h72);
    rdx(8'h96, 8'h00);
    rdx(8'h97, 8'h00);
    rdx(8'h3c, 8'h00);
    // low first, then high triggers the load
    repeat (4) begin
      r = 8'($random(seed));
      i_cpu.acc(1, 8'h96, r);
      i_cpu.acc(1, 8'h97, ~r);
      ld({~r, r[7:6]});
      rdx(8'h96, r & 8'hc0);
    end
    // every range code, spare control bits set
    for (int i = 0; i < 4; i++) begin
      i_cpu.acc(1, 8'hb9, 8'h7c | i[7:0]);
      rdx(8'hb9, 8'h70 | i[7:0]);
      `CHK(FULL_SCALE_O, i[1] ? 2'h2 : i[1:0])
    end
    `CHK({CONVERTER_ENABLE_O, PIN_ANALOG_O}, 2'h0)
    // low preset once; a foreign timer goes first
    i_cpu.acc(1, 8'h96, 8'h00);
    for (int t = 0; t < 4; t++) begin
      i_cpu.acc(1, 8'hb9, {1'b1, t[2:0], 4'h2});
      i_cpu.acc(1, 8'h97, {4'h2, t[3:0]});
      tick(4'h1 << (t + 1) % 4);
      ld({4'h2, t[3:0], 2'h0});
      tick(4'h1 << t);
    end
    `CHK({CONVERTER_ENABLE_O, PIN_ANALOG_O}, 2'h3)
    // rise, fall and either edge; new data between the edges
    for (int m = 4; m < 7; m++) begin
      i_cpu.acc(1, 8'hb9, {1'b1, m[2:0], 4'h2});
      i_cpu.acc(1, 8'h97, {4'h8, m[3:0]});
      if (m != 5) ld({4'h8, m[3:0], 2'h0});
      pin(1);
      i_cpu.acc(1, 8'h97, {4'h9, m[3:0]});
      if (m != 4) ld({4'h9, m[3:0], 2'h0});
      pin(0);
    end
    wrap_up;
  end
  // single exit; leftover notes mean a missed load or a missed read check
  task wrap_up;
    `CHK(dq.size() + rq.size(), 0)
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // the sequence needs well under 20 us
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
